//--- verilog/dcfd_params.svh
`ifndef DCFD_PARAMS_SVH
`define DCFD_PARAMS_SVH
// apb register byte addresses
`define DCFD_ADDR_STATUS 12'h000
`define DCFD_ADDR_OSC 12'h004
`define DCFD_ADDR_WDT 12'h008
`define DCFD_ADDR_SOFT 12'h00c
// fuse word bit positions
`define DCFD_B_CP 0
`define DCFD_B_WP 1
`define DCFD_B_TWO_SPEED_STARTUP_EN 2
`define DCFD_B_PWML 3
`define DCFD_B_OSC_LO 4
`define DCFD_B_CKSM_LO 7
`define DCFD_B_PIN1 9
`define DCFD_B_OSC2F 10
`define DCFD_B_POSC_LO 11
`define DCFD_B_WDTF 13
`define DCFD_B_WIN 14
`define DCFD_B_DBG 15
// erased fuses read all ones
`define DCFD_FUSE_ERASED 16'hffff
// start-up ready wait after reset in cycles
`define DCFD_READY_CYC 8'h10
`endif

//--- verilog/dcfd_pkg.sv
package dcfd_pkg;
   typedef enum logic [2:0] {
      DCFD_OSC_FRC = 3'h0,
      DCFD_OSC_FRCPLL = 3'h1,
      DCFD_OSC_PRI = 3'h2,
      DCFD_OSC_PRIPLL = 3'h3,
      DCFD_OSC_RSVD = 3'h4,
      DCFD_OSC_LOW_POWER_RC_OSC = 3'h5,
      DCFD_OSC_FRC16 = 3'h6,
      DCFD_OSC_FRCDIVN = 3'h7
   } dcfd_osc_e;
   typedef enum logic [1:0] {
      DCFD_POSC_EC = 2'h0,
      DCFD_POSC_XT = 2'h1,
      DCFD_POSC_HS = 2'h2,
      DCFD_POSC_OFF = 2'h3
   } dcfd_posc_e;
   typedef enum logic [2:0] {
      DCFD_ST_LOAD = 3'h1,
      DCFD_ST_START = 3'h2,
      DCFD_ST_RUN = 3'h4
   } dcfd_state_e;
   typedef struct packed {
      logic code_protect;
      logic write_protect;
      logic pwm_key_lock_en;
      logic pin_map_single_reconfig;
      logic debug_tms_pullup;
   } dcfd_prot_s;
   typedef struct packed {
      dcfd_osc_e osc_source_select;
      dcfd_posc_e primary_osc_mode;
      logic clock_switch_en;
      logic fail_safe_monitor_en;
      logic osc_pin_two_clkout;
      logic two_speed_startup_en;
   } dcfd_clk_s;
   typedef struct packed {
      logic watchdog_run;
      logic watchdog_window_mode;
      logic low_power_rc_osc_may_stop;
   } dcfd_wdt_s;
endpackage

//--- verilog/dcfd_fuse_latch.sv
`timescale 1ns/1ps
`include "dcfd_params.svh"
// holds the fuse word; loads only on the load strobe after reset
module dcfd_fuse_latch #(
   parameter int WIDTH = 16
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [WIDTH-1:0] fuse_in,
   output logic [WIDTH-1:0] fuse_q
);
   // bit positions of the decode are fixed, so only one width is served
   if (WIDTH != 16)
   begin : g_bad_width
      $error("fuse width must be 16");
   end
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         fuse_q <= WIDTH'(`DCFD_FUSE_ERASED);
      else if (load)
         fuse_q <= fuse_in;
   end
endmodule

//--- verilog/dcfd_apb_regs.sv
`timescale 1ns/1ps
`include "dcfd_params.svh"
// apb slave, zero wait states, pslverr on unmapped address
module dcfd_apb_regs (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] rd_status,
   input wire logic [31:0] rd_osc,
   input wire logic [31:0] rd_wdt,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic soft_wdt_en
);
   wire logic setup = psel && !penable;
   // writes land only at the edge that completes the access phase
   wire logic access = psel && penable && pready;
   wire logic hit_st = paddr == `DCFD_ADDR_STATUS;
   wire logic hit_osc = paddr == `DCFD_ADDR_OSC;
   wire logic hit_wdt = paddr == `DCFD_ADDR_WDT;
   wire logic hit_soft = paddr == `DCFD_ADDR_SOFT;
   wire logic mapped = hit_st || hit_osc || hit_wdt || hit_soft;
   wire logic [31:0] rd_mux = hit_st ? rd_status :
                              hit_osc ? rd_osc :
                              hit_wdt ? rd_wdt :
                              hit_soft ? {31'h0, soft_wdt_en} : 32'h0;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         soft_wdt_en <= 1'b0;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup && !mapped;
         prdata <= (setup && !pwrite) ? rd_mux : 32'h0;
         if (access && pwrite && hit_soft)
            soft_wdt_en <= pwdata[0];
      end
   end
endmodule

//--- verilog/dcfd_top.sv
`timescale 1ns/1ps
`include "dcfd_params.svh"
module dcfd_top (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [15:0] fuse_word,
   input wire logic source_ready,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output dcfd_pkg::dcfd_prot_s prot,
   output dcfd_pkg::dcfd_clk_s clk_cfg,
   output dcfd_pkg::dcfd_wdt_s wdt_cfg,
   output dcfd_pkg::dcfd_osc_e active_osc,
   output logic cfg_valid
);
   ////////////////////////////////////////////////////////////////////////
   dcfd_pkg::dcfd_state_e state;
   dcfd_pkg::dcfd_state_e next_state;
   logic [15:0] fuse_q;
   logic soft_wdt_en;
   logic [7:0] wait_cnt;
   logic loaded;

   // fuse word is loaded in the one cycle after reset release only
   wire logic load_now = state == dcfd_pkg::DCFD_ST_LOAD;

   dcfd_fuse_latch #(.WIDTH(16)) u_latch (
      .sys_clk(sys_clk),
      .rst(rst),
      .load(load_now),
      .fuse_in(fuse_word),
      .fuse_q(fuse_q)
   );

   ////////////////////////////////////////////////////////////////////////
   function automatic dcfd_pkg::dcfd_osc_e osc_of(input logic [2:0] f);
      osc_of = dcfd_pkg::dcfd_osc_e'(f);
   endfunction

   function automatic logic is_crystal(input logic [1:0] p);
      is_crystal = p == dcfd_pkg::DCFD_POSC_XT ||
                   p == dcfd_pkg::DCFD_POSC_HS;
   endfunction

   wire logic [2:0] f_osc = fuse_q[`DCFD_B_OSC_LO +: 3];
   wire logic [1:0] f_cksm = fuse_q[`DCFD_B_CKSM_LO +: 2];
   wire logic [1:0] f_posc = fuse_q[`DCFD_B_POSC_LO +: 2];
   wire dcfd_pkg::dcfd_osc_e sel_osc = osc_of(f_osc);

   // 1x: both off, 01: switching only, 00: both
   wire logic sw_en = !f_cksm[1];
   wire logic fscm_en = f_cksm == 2'h0;

   dcfd_pkg::dcfd_prot_s next_prot;
   dcfd_pkg::dcfd_clk_s next_clk;
   dcfd_pkg::dcfd_wdt_s next_wdt;
   dcfd_pkg::dcfd_osc_e next_active;

   assign next_prot.code_protect = !fuse_q[`DCFD_B_CP];
   assign next_prot.write_protect = !fuse_q[`DCFD_B_WP];
   assign next_prot.pwm_key_lock_en = fuse_q[`DCFD_B_PWML];
   assign next_prot.pin_map_single_reconfig =
      fuse_q[`DCFD_B_PIN1];
   assign next_prot.debug_tms_pullup = fuse_q[`DCFD_B_DBG];

   assign next_clk.osc_source_select = sel_osc;
   assign next_clk.primary_osc_mode =
      dcfd_pkg::dcfd_posc_e'(f_posc);
   assign next_clk.clock_switch_en = sw_en;
   assign next_clk.fail_safe_monitor_en = fscm_en;
   // crystal modes own the pin, so clock out is suppressed there
   assign next_clk.osc_pin_two_clkout =
      fuse_q[`DCFD_B_OSC2F] && !is_crystal(f_posc);
   assign next_clk.two_speed_startup_en = fuse_q[`DCFD_B_TWO_SPEED_STARTUP_EN];

   // forced watchdog ignores the soft enable bit
   wire logic wdt_force = fuse_q[`DCFD_B_WDTF];
   assign next_wdt.watchdog_run = wdt_force || soft_wdt_en;
   assign next_wdt.low_power_rc_osc_may_stop = !wdt_force;
   assign next_wdt.watchdog_window_mode =
      !fuse_q[`DCFD_B_WIN];

   // two-speed: fast rc until the chosen source reports ready or the ready wait count runs out
   wire logic on_frc = fuse_q[`DCFD_B_TWO_SPEED_STARTUP_EN] &&
                       state != dcfd_pkg::DCFD_ST_RUN;
   assign next_active = on_frc ? dcfd_pkg::DCFD_OSC_FRC : sel_osc;

   ////////////////////////////////////////////////////////////////////////
   wire logic wait_done = wait_cnt == `DCFD_READY_CYC;
   wire logic go_run = source_ready || wait_done;

   always_comb
   begin
      next_state = state;
      case (state)
         dcfd_pkg::DCFD_ST_LOAD: next_state = dcfd_pkg::DCFD_ST_START;
         dcfd_pkg::DCFD_ST_START:
            if (go_run || !fuse_q[`DCFD_B_TWO_SPEED_STARTUP_EN])
               next_state = dcfd_pkg::DCFD_ST_RUN;
         dcfd_pkg::DCFD_ST_RUN: next_state = dcfd_pkg::DCFD_ST_RUN;
         default: next_state = dcfd_pkg::DCFD_ST_LOAD;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state <= dcfd_pkg::DCFD_ST_LOAD;
         wait_cnt <= 8'h00;
         loaded <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (state == dcfd_pkg::DCFD_ST_START && !wait_done)
            wait_cnt <= wait_cnt + 8'h01;
         if (load_now)
            loaded <= 1'b1;
      end
   end

   // outputs registered; erased-state values shown during reset
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         prot <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
         clk_cfg <= '{dcfd_pkg::DCFD_OSC_FRCDIVN, dcfd_pkg::DCFD_POSC_OFF,
                      1'b0, 1'b0, 1'b1, 1'b1};
         wdt_cfg <= '{1'b1, 1'b0, 1'b0};
         active_osc <= dcfd_pkg::DCFD_OSC_FRC;
         cfg_valid <= 1'b0;
      end
      else
      begin
         prot <= next_prot;
         clk_cfg <= next_clk;
         wdt_cfg <= next_wdt;
         active_osc <= next_active;
         cfg_valid <= loaded;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   wire logic [31:0] rd_status = {25'h0, state == dcfd_pkg::DCFD_ST_RUN,
                                  cfg_valid, prot};
   wire logic [31:0] rd_osc = {20'h0, active_osc, clk_cfg};
   wire logic [31:0] rd_wdt = {29'h0, wdt_cfg};

   dcfd_apb_regs u_regs (
      .sys_clk(sys_clk),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .rd_status(rd_status),
      .rd_osc(rd_osc),
      .rd_wdt(rd_wdt),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .soft_wdt_en(soft_wdt_en)
   );

   ////////////////////////////////////////////////////////////////////////
   a_cp_decode: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid |-> prot.code_protect == !fuse_q[`DCFD_B_CP])
      else $error("code protect mismatch");
   a_wp_decode: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid |-> prot.write_protect == !fuse_q[`DCFD_B_WP])
      else $error("write protect mismatch");
   a_two_speed: assert property (@(posedge sys_clk) disable iff (rst)
      (cfg_valid && fuse_q[`DCFD_B_TWO_SPEED_STARTUP_EN] && state == dcfd_pkg::DCFD_ST_START)
      |=> active_osc == dcfd_pkg::DCFD_OSC_FRC)
      else $error("two-speed not on fast rc");
   a_pwm_lock: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid |-> prot.pwm_key_lock_en == fuse_q[`DCFD_B_PWML])
      else $error("pwm lock mismatch");
   a_osc_sel: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid |-> clk_cfg.osc_source_select == f_osc)
      else $error("osc select mismatch");
   a_fscm_mode: assert property (@(posedge sys_clk) disable iff (rst)
      clk_cfg.fail_safe_monitor_en |-> clk_cfg.clock_switch_en)
      else $error("monitor without switching");
   a_pin_map: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid |-> prot.pin_map_single_reconfig ==
      fuse_q[`DCFD_B_PIN1])
      else $error("pin map mismatch");
   a_osc_pin_two_xtal: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_cfg.primary_osc_mode == dcfd_pkg::DCFD_POSC_XT ||
       clk_cfg.primary_osc_mode == dcfd_pkg::DCFD_POSC_HS)
      |-> !clk_cfg.osc_pin_two_clkout)
      else $error("clock out in crystal mode");
   a_posc_mode: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid |-> clk_cfg.primary_osc_mode == f_posc)
      else $error("primary mode mismatch");
   a_wdt_force: assert property (@(posedge sys_clk) disable iff (rst)
      (cfg_valid && wdt_force) |-> wdt_cfg.watchdog_run &&
      !wdt_cfg.low_power_rc_osc_may_stop)
      else $error("forced watchdog not running");
   a_wdt_window: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid |-> wdt_cfg.watchdog_window_mode ==
      !fuse_q[`DCFD_B_WIN])
      else $error("window mode mismatch");
   a_dbg_pullup: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid |-> prot.debug_tms_pullup == fuse_q[`DCFD_B_DBG])
      else $error("debug pull-up mismatch");
   a_cfg_stable: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid ##1 cfg_valid |-> $stable(fuse_q))
      else $error("fuses changed after load");

   ////////////////////////////////////////////////////////////////////////
   // decode checks for the fields not covered above
   a_sw_decode: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid |-> clk_cfg.clock_switch_en == !f_cksm[1])
      else $error("switch enable mismatch");

   a_fscm_decode: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid |-> clk_cfg.fail_safe_monitor_en ==
      (f_cksm == 2'h0))
      else $error("monitor enable mismatch");

   a_osc_pin_two_func: assert property (@(posedge sys_clk) disable iff (rst)
      (cfg_valid && !is_crystal(f_posc)) |->
      clk_cfg.osc_pin_two_clkout == fuse_q[`DCFD_B_OSC2F])
      else $error("pin two function mismatch");

   a_two_speed_startup_en_flag: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid |-> clk_cfg.two_speed_startup_en ==
      fuse_q[`DCFD_B_TWO_SPEED_STARTUP_EN])
      else $error("two-speed flag mismatch");

   ////////////////////////////////////////////////////////////////////////
   // start-up sequencing
   a_direct_start: assert property (@(posedge sys_clk) disable iff (rst)
      (cfg_valid && !fuse_q[`DCFD_B_TWO_SPEED_STARTUP_EN]) |->
      active_osc == sel_osc)
      else $error("direct start not on selected source");

   a_run_switch: assert property (@(posedge sys_clk) disable iff (rst)
      state == dcfd_pkg::DCFD_ST_RUN |=> active_osc == sel_osc)
      else $error("running but not on selected source");

   a_start_leave: assert property (@(posedge sys_clk) disable iff (rst)
      (state == dcfd_pkg::DCFD_ST_START &&
       (source_ready || !fuse_q[`DCFD_B_TWO_SPEED_STARTUP_EN]))
      |=> state == dcfd_pkg::DCFD_ST_RUN)
      else $error("ready source not taken");

   // the counter must never run past its limit, or start could hang
   a_wait_bound: assert property (@(posedge sys_clk) disable iff (rst)
      wait_cnt <= `DCFD_READY_CYC)
      else $error("ready wait overrun");

   ////////////////////////////////////////////////////////////////////////
   // watchdog under software control when not forced
   a_wdt_soft: assert property (@(posedge sys_clk) disable iff (rst)
      (cfg_valid && !wdt_force) |->
      wdt_cfg.watchdog_run == $past(soft_wdt_en))
      else $error("soft watchdog enable ignored");

   a_low_power_rc_osc_free: assert property (@(posedge sys_clk) disable iff (rst)
      (cfg_valid && !wdt_force) |-> wdt_cfg.low_power_rc_osc_may_stop)
      else $error("low-power rc held without force");

   ////////////////////////////////////////////////////////////////////////
   // once valid, the protection and clock decode holds until the next reset
   a_state_onehot: assert property (@(posedge sys_clk) disable iff (rst)
      $onehot(state))
      else $error("state not one-hot");

   a_valid_hold: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid |=> cfg_valid)
      else $error("valid dropped");

   a_prot_hold: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid ##1 cfg_valid |-> $stable(prot))
      else $error("protection outputs changed");

   a_clk_hold: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_valid ##1 cfg_valid |-> $stable(clk_cfg))
      else $error("clock outputs changed");
endmodule

//--- tb/test_device_config_fuse_decode.sv
`timescale 1ns/1ps
`include "dcfd_params.svh"
module test_device_config_fuse_decode;
   logic sys_clk;
   logic rst;
   logic [15:0] fuse_word;
   logic source_ready;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   dcfd_pkg::dcfd_prot_s prot;
   dcfd_pkg::dcfd_clk_s clk_cfg;
   dcfd_pkg::dcfd_wdt_s wdt_cfg;
   dcfd_pkg::dcfd_osc_e active_osc;
   logic cfg_valid;
   int err_total;
   int compares;
   dcfd_top i_dcfd_top (.sys_clk(sys_clk), .rst(rst), .fuse_word(fuse_word),
      .source_ready(source_ready), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .prot(prot), .clk_cfg(clk_cfg),
      .wdt_cfg(wdt_cfg), .active_osc(active_osc), .cfg_valid(cfg_valid));
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
////////////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] exp_prot(input logic [15:0] f);
      exp_prot = {~f[0], ~f[1], f[3], f[9], f[15]};
   endfunction
   // clock out is lost whenever a crystal owns the second pin
   function automatic logic [8:0] exp_clk(input logic [15:0] f);
      logic xtal;
      xtal = (f[12:11] == 2'h1) || (f[12:11] == 2'h2);
      exp_clk = {f[6:4], f[12:11], ~f[8], f[8:7] == 2'h0, f[10] & ~xtal, f[2]};
   endfunction
   function automatic logic [2:0] exp_wdt(input logic [15:0] f, input logic s);
      exp_wdt = {f[13] | s, ~f[14], ~f[13]};
   endfunction
   // spreads a 3-bit index over every field so each code is reached
   function automatic logic [15:0] fz(input logic [2:0] i);
      fz = {i, i[1:0], ~i[2], i[1], i[1:0], i, ~i[0], i[2], i[1], i[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      // ready and data are read mid-cycle, where they stand settled
      do
      begin
         @(negedge sys_clk);
         n++;
         rd = prdata;
         er = pslverr;
      end
      while (pready !== 1'b1 && n < 20);
      @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n < 20, 1'b1, "apb answer");
   endtask
////////////////////////////////////////////////////////////////////////////
   task automatic load(input logic [15:0] f);
      @(posedge sys_clk);
      rst <= 1'b1;
      fuse_word <= f;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      chk(prot, exp_prot(`DCFD_FUSE_ERASED), "reset prot");
      chk(clk_cfg, exp_clk(`DCFD_FUSE_ERASED), "reset clk");
      chk(wdt_cfg, exp_wdt(`DCFD_FUSE_ERASED, 1'b0), "reset wdt");
      chk({active_osc, cfg_valid}, 4'h0, "reset osc valid");
      repeat (3) @(posedge sys_clk);
      #1;
      chk(cfg_valid, 1'b1, "cfg valid");
      chk(prot, exp_prot(f), "prot");
      chk(clk_cfg, exp_clk(f), "clk");
      chk(wdt_cfg, exp_wdt(f, 1'b0), "wdt");
   endtask
   task automatic two_speed(input logic [15:0] f);
      int n;
      chk(active_osc, f[2] ? 3'h0 : f[6:4], "start osc");
      @(posedge sys_clk);
      source_ready <= 1'b1;
      #1;
      n = 0;
      while (active_osc !== f[6:4] && n < 20)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk(active_osc, f[6:4], "switched osc");
      @(posedge sys_clk);
      source_ready <= 1'b0;
   endtask
   task automatic regs(input logic [15:0] f);
      logic [31:0] rd;
      logic er;
      apb(1'b0, `DCFD_ADDR_STATUS, 32'h0, rd, er);
      chk(rd, {25'h0, 2'h3, exp_prot(f)}, "status reg");
      apb(1'b0, `DCFD_ADDR_OSC, 32'h0, rd, er);
      chk(rd, {20'h0, f[6:4], exp_clk(f)}, "osc reg");
      apb(1'b0, `DCFD_ADDR_WDT, 32'h0, rd, er);
      chk(rd[2:0], exp_wdt(f, 1'b0), "wdt reg");
      apb(1'b1, `DCFD_ADDR_SOFT, 32'h1, rd, er);
      apb(1'b0, `DCFD_ADDR_SOFT, 32'h0, rd, er);
      chk(rd[0], 1'b1, "soft reg");
      repeat (3) @(posedge sys_clk);
      #1;
      chk(wdt_cfg, exp_wdt(f, 1'b1), "soft on");
      apb(1'b1, `DCFD_ADDR_SOFT, 32'h0, rd, er);
      repeat (3) @(posedge sys_clk);
      #1;
      chk(wdt_cfg, exp_wdt(f, 1'b0), "soft off");
      // unmapped place must refuse and leave real state alone
      apb(1'b1, 12'h010, 32'hffffffff, rd, er);
      chk(er, 1'b1, "unmapped write err");
      apb(1'b0, 12'h010, 32'h0, rd, er);
      chk({er, rd}, {1'b1, 32'h0}, "unmapped read");
      fuse_word <= ~f;
      repeat (4) @(posedge sys_clk);
      #1;
      chk({prot, clk_cfg}, {exp_prot(f), exp_clk(f)}, "held");
   endtask
////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      err_total++;
      $display("Error at %0t: watchdog expired", $time);
      tally_and_finish();
   end
   initial
   begin
      err_total = 0;
      compares = 0;
      rst = 1'b1;
      fuse_word = `DCFD_FUSE_ERASED;
      source_ready = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      @(posedge sys_clk);
      for (int i = 0; i < 8; i++)
      begin
         load(fz(i[2:0]));
         two_speed(fz(i[2:0]));
         regs(fz(i[2:0]));
      end
      tally_and_finish();
   end
endmodule
